/* verilog/sps_pkg.sv */
// Shared constants and types for the security page command block.
`default_nettype none
package sps_pkg;
    // Clock rate and self-timed operation lengths.
    localparam int CLK_MHZ = 25;
    localparam int ERASE_TIME_US = 1000; // Plain default, not a part figure.
    localparam int PROG_TIME_US = 500; // Plain default, not a part figure.
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int TMR_W = 24;
    // Opcodes.
    localparam logic [7:0] OPC_NONE = 8'h00;
    localparam logic [7:0] OPC_WR_DIS = 8'h04;
    localparam logic [7:0] OPC_RD_STAT = 8'h05;
    localparam logic [7:0] OPC_WR_EN = 8'h06;
    localparam logic [7:0] OPC_SEC_PROG = 8'h42;
    localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
    localparam logic [7:0] OPC_SEC_READ = 8'h48;
    // Page addressing.
    localparam logic [7:0] PAGE_HI_BYTE = 8'h00;
    localparam logic [7:0] PAGE_FIRST = 8'h01;
    localparam logic [7:0] PAGE_LAST = 8'h03;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // Byte counts of a frame, opcode included.
    localparam logic [2:0] CNT_ADDR_LAST = 3'h3;
    localparam logic [2:0] CNT_ERASE = 3'h4;
    localparam logic [2:0] CNT_PROG_MIN = 3'h5;
    localparam logic [2:0] CNT_SAT = 3'h7;
    // Status byte field positions.
    localparam int ST_BIT_BUSY = 0;
    localparam int ST_BIT_WEN = 1;
    localparam int ST_BIT_LOCK = 2;
    // Reset values; pin order is {wp_n, si, sclk, cs_n}.
    localparam logic [3:0] SYNC_RST = 4'h9;
    localparam logic [5:0] PROT_RST = 6'h00;
    localparam logic [2:0] LOCK_RST = 3'h0;
    // Command decoder states.
    typedef enum logic [6:0] {
        ST_OPC = 7'h01,
        ST_ADDR = 7'h02,
        ST_DATA = 7'h04,
        ST_DUMMY = 7'h08,
        ST_READ = 7'h10,
        ST_STAT = 7'h20,
        ST_IGNORE = 7'h40
    } sps_state_e;
endpackage : sps_pkg
`default_nettype wire

/* verilog/sps_byte_if.sv */
// Byte stream carrier with valid and ready.
`default_nettype none
interface sps_byte_if #(parameter int W = 8);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface : sps_byte_if
`default_nettype wire

/* verilog/sps_buf2.sv */
// Two-entry buffer between the bit shifter and the command decoder.
`default_nettype none
module sps_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Filling and draining sides.
    sps_byte_if.snk i_in,
    sps_byte_if.src o_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] slot_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    // Full and empty come straight from the fill count.
    assign i_in.ready = (cnt_reg != (AW+1)'(DEPTH));
    assign o_out.valid = (cnt_reg != '0);
    assign o_out.data = slot_reg[rd_ptr_reg];
    assign push = i_in.valid & i_in.ready;
    assign pop = o_out.valid & o_out.ready;

    // Storage needs no reset; the count guards every read.
    always_ff @(posedge i_clk) begin
        if (push) begin
            slot_reg[wr_ptr_reg] <= i_in.data;
        end
    end

    // Pointers wrap at the power-of-two depth.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + AW'(1);
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - (AW+1)'(1);
            end
        end
    end
endmodule : sps_buf2
`default_nettype wire

/* verilog/sps_shifter.sv */
// Serial bit shifter: collects input bytes and shifts output bytes.
`default_nettype none
module sps_shifter (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Synchronised serial pins.
    input wire logic i_sclk_s,
    input wire logic i_si_s,
    input wire logic i_cs_n_s,
    // Received bytes.
    sps_byte_if.src o_rx,
    // Transmit side.
    input wire logic i_tx_en,
    input wire logic [7:0] i_tx_byte,
    output logic o_so,
    output logic o_tx_take,
    // Frame end.
    output logic o_cs_rise,
    output logic o_aligned
);
    logic sclk_d_reg;
    logic cs_d_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] rx_sh_reg;
    logic [2:0] tx_cnt_reg;
    logic [6:0] tx_sh_reg;
    logic sck_rise;
    logic sck_fall;

    // Edges count only inside a frame.
    assign sck_rise = i_sclk_s & ~sclk_d_reg & ~i_cs_n_s;
    assign sck_fall = ~i_sclk_s & sclk_d_reg & ~i_cs_n_s;

    // Delayed copies for edge detection.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sclk_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= i_sclk_s;
            cs_d_reg <= i_cs_n_s;
        end
    end

    // Input bits are taken on the rising clock edge, MSB first.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bit_cnt_reg <= 3'h0;
            rx_sh_reg <= 7'h00;
            o_rx.valid <= 1'b0;
            o_rx.data <= 8'h00;
        end else begin
            if (o_rx.valid && o_rx.ready) begin
                o_rx.valid <= 1'b0;
            end
            if (i_cs_n_s) begin
                bit_cnt_reg <= 3'h0;
            end else if (sck_rise) begin
                rx_sh_reg <= {rx_sh_reg[5:0], i_si_s};
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    o_rx.data <= {rx_sh_reg, i_si_s};
                    o_rx.valid <= 1'b1;
                end
            end
        end
    end

    // Frame end strobe, with the bit count seen before it is cleared.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cs_rise <= 1'b0;
            o_aligned <= 1'b1;
        end else begin
            o_cs_rise <= i_cs_n_s & ~cs_d_reg;
            o_aligned <= (bit_cnt_reg == 3'h0);
        end
    end

    // Output bits change on the falling edge; a new byte loads every 8th.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_cnt_reg <= 3'h0;
            tx_sh_reg <= 7'h00;
            o_so <= 1'b0;
            o_tx_take <= 1'b0;
        end else begin
            o_tx_take <= 1'b0;
            if (i_cs_n_s) begin
                tx_cnt_reg <= 3'h0;
            end else if (sck_fall && i_tx_en) begin
                tx_cnt_reg <= tx_cnt_reg + 3'h1;
                if (tx_cnt_reg == 3'h0) begin
                    o_so <= i_tx_byte[7];
                    tx_sh_reg <= i_tx_byte[6:0];
                    o_tx_take <= 1'b1;
                end else begin
                    o_so <= tx_sh_reg[6];
                    tx_sh_reg <= {tx_sh_reg[5:0], 1'b0};
                end
            end
        end
    end
endmodule : sps_shifter
`default_nettype wire

/* verilog/sps_top.sv */
// Security page command engine of a serial flash device.
// Overview of operation
// - Protect pin only gates the lock on protection bits, never the array.
// - Protect pin low refuses every change of the protection bits.
// - Three security pages, each erased, programmed and locked alone.
// - Erase 44h plus three address bytes starts on chip select release.
// - Erase ignores the low address byte but needs all three bytes.
// - Erase aborts unless chip select rises right after the last bit.
// - Busy flag is set during erase and clears at completion.
// - Erase abort for length, alignment or protection clears the latch.
// - Page lock bits are one-time: once set they never clear.
// - Erase of a locked page is ignored, contents unchanged.
// - Pages sit at 00h, 01h..03h; low byte is the byte offset.
// - Page program uses the 256-byte buffer, overwriting it.
// - Program 42h takes three address bytes giving the start byte.
// - Read 48h takes three address bytes, a dummy, then streams data.
// - Read wraps from 0003FFh to 000000h with no extra cycles.
// - Chip select release ends a read and floats the output.
// - Write enable 06h sets the latch on a byte-aligned release.
`default_nettype none
module sps_top #(
    parameter int unsigned ERASE_CYC = sps_pkg::ERASE_CYCLES,
    parameter int unsigned PROG_CYC = sps_pkg::PROG_CYCLES
) (
    // Clock and reset.
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Serial interface pins.
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe_n,
    // Hardware protect pin and protection bits.
    input wire logic i_wp_n,
    input wire logic i_prot_wr,
    input wire logic [5:0] i_prot_data,
    output logic [5:0] o_prot_bits,
    output logic o_prot_refused,
    // Page lock bits.
    input wire logic i_lock_wr,
    input wire logic [2:0] i_lock_data,
    output logic [2:0] o_lock_bits,
    // Status.
    output logic o_busy,
    output logic o_wen
);
    import sps_pkg::*;

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [3:0] pin_raw;
    logic [3:0] pin_s;
    logic cs_n_s;
    logic sclk_s;
    logic si_s;
    logic wp_n_s;
    logic tx_take;
    logic cs_rise;
    logic cs_aligned;
    logic [7:0] tx_byte;
    logic [7:0] stat_byte;
    sps_state_e state_reg;
    logic [7:0] cmd_reg;
    logic [2:0] cnt_reg;
    logic [23:0] addr_reg;
    logic [7:0] off_reg;
    logic [9:0] rd_addr_reg;
    logic tx_en_reg;
    logic end_pend_reg;
    logic end_aln_reg;
    logic wen_reg;
    logic busy_reg;
    logic sweep_reg;
    logic erase_mode_reg;
    logic [7:0] idx_reg;
    logic [1:0] page_reg;
    logic [TMR_W-1:0] tmr_reg;
    logic [255:0] mask_reg;
    logic [5:0] prot_reg;
    logic refused_reg;
    logic [2:0] lock_reg;
    logic oe_n_reg;
    logic [7:0] mem [1024];
    logic [7:0] pbuf [256];
    logic pop;
    logic [7:0] rx;
    logic end_go;
    logic page_ok;
    logic locked;
    logic erase_ok;
    logic prog_ok;
    logic eng_done;

    sps_byte_if #(.W(8)) rx_if ();
    sps_byte_if #(.W(8)) cmd_if ();

    // Reset is released through two flops so every flop leaves it together.
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Every pin passes two flops; only the second one is read.
    assign pin_raw = {i_wp_n, i_si, i_sclk, i_cs_n};
    for (genvar i = 0; i < 4; i++) begin : g_sync
        logic s1_reg;
        logic s2_reg;
        always_ff @(posedge i_mclk or negedge rst_n) begin
            if (!rst_n) begin
                s1_reg <= SYNC_RST[i];
                s2_reg <= SYNC_RST[i];
            end else begin
                s1_reg <= pin_raw[i];
                s2_reg <= s1_reg;
            end
        end
        assign pin_s[i] = s2_reg;
    end
    assign cs_n_s = pin_s[0];
    assign sclk_s = pin_s[1];
    assign si_s = pin_s[2];
    assign wp_n_s = pin_s[3];

    sps_shifter u_shift (
        .i_clk(i_mclk),
        .i_rst_n(rst_n),
        .i_sclk_s(sclk_s),
        .i_si_s(si_s),
        .i_cs_n_s(cs_n_s),
        .o_rx(rx_if),
        .i_tx_en(tx_en_reg),
        .i_tx_byte(tx_byte),
        .o_so(o_so),
        .o_tx_take(tx_take),
        .o_cs_rise(cs_rise),
        .o_aligned(cs_aligned)
    );

    sps_buf2 #(.WIDTH(8), .DEPTH(2)) u_buf (
        .i_clk(i_mclk),
        .i_rst_n(rst_n),
        .i_in(rx_if),
        .o_out(cmd_if)
    );

    // Decoding pauses during the array sweep; the buffer holds the bytes.
    assign cmd_if.ready = ~sweep_reg;
    assign pop = cmd_if.valid & cmd_if.ready;
    assign rx = cmd_if.data;
    // A frame is judged only once all its bytes have been decoded.
    assign end_go = end_pend_reg & ~cmd_if.valid;

    // Page decode; page 0 counts as locked so it can never be altered.
    assign page_ok = (addr_reg[23:16] == PAGE_HI_BYTE) &&
                     (addr_reg[15:8] >= PAGE_FIRST) &&
                     (addr_reg[15:8] <= PAGE_LAST);
    assign locked = ({lock_reg, 1'b1} >> addr_reg[9:8]) != 4'h0 &&
                    (({lock_reg, 1'b1} >> addr_reg[9:8]) & 4'h1) != 4'h0;
    // The low address byte plays no part in the erase target.
    assign erase_ok = (cmd_reg == OPC_SEC_ERASE) && (cnt_reg == CNT_ERASE) &&
                      end_aln_reg && wen_reg && page_ok &&
                      !locked;
    assign prog_ok = (cmd_reg == OPC_SEC_PROG) &&
                     (cnt_reg >= CNT_PROG_MIN) && end_aln_reg &&
                     wen_reg && page_ok && !locked;
    assign eng_done = busy_reg && (tmr_reg == '0);

    // Status byte shifted out by the status read.
    always_comb begin
        stat_byte = 8'h00;
        stat_byte[ST_BIT_BUSY] = busy_reg;
        stat_byte[ST_BIT_WEN] = wen_reg;
        stat_byte[ST_BIT_LOCK +: 3] = lock_reg;
    end
    assign tx_byte = (state_reg == ST_STAT) ? stat_byte : mem[rd_addr_reg];

    // Command decoder: opcode, address, data or dummy, then streaming.
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_OPC;
            cmd_reg <= OPC_NONE;
            cnt_reg <= 3'h0;
            addr_reg <= 24'h000000;
            off_reg <= 8'h00;
            rd_addr_reg <= 10'h000;
            tx_en_reg <= 1'b0;
            end_pend_reg <= 1'b0;
            end_aln_reg <= 1'b0;
        end else begin
            if (end_go) begin
                end_pend_reg <= 1'b0;
                state_reg <= ST_OPC;
                cmd_reg <= OPC_NONE;
                cnt_reg <= 3'h0;
                tx_en_reg <= 1'b0;
            end else if (pop) begin
                if (cnt_reg != CNT_SAT) begin
                    cnt_reg <= cnt_reg + 3'h1;
                end
                case (state_reg)
                    ST_OPC: begin
                        // While busy only the status read is honoured.
                        if (busy_reg && rx != OPC_RD_STAT) begin
                            cmd_reg <= OPC_NONE;
                            state_reg <= ST_IGNORE;
                        end else begin
                            cmd_reg <= rx;
                            case (rx)
                                OPC_SEC_ERASE, OPC_SEC_PROG,
                                OPC_SEC_READ: begin
                                    state_reg <= ST_ADDR;
                                end
                                OPC_RD_STAT: begin
                                    state_reg <= ST_STAT;
                                    tx_en_reg <= 1'b1;
                                end
                                default: begin
                                    state_reg <= ST_IGNORE;
                                end
                            endcase
                        end
                    end
                    ST_ADDR: begin
                        addr_reg <= {addr_reg[15:0], rx};
                        if (cnt_reg == CNT_ADDR_LAST) begin
                            off_reg <= rx;
                            if (cmd_reg == OPC_SEC_READ) begin
                                state_reg <= ST_DUMMY;
                            end else if (cmd_reg == OPC_SEC_PROG) begin
                                state_reg <= ST_DATA;
                            end else begin
                                state_reg <= ST_IGNORE;
                            end
                        end
                    end
                    ST_DATA: begin
                        off_reg <= off_reg + 8'h01;
                    end
                    ST_DUMMY: begin
                        state_reg <= ST_READ;
                        tx_en_reg <= 1'b1;
                        rd_addr_reg <= addr_reg[9:0];
                    end
                    ST_READ, ST_STAT, ST_IGNORE: begin
                        state_reg <= state_reg;
                    end
                    default: begin
                        state_reg <= ST_IGNORE;
                    end
                endcase
            end
            // Ten-bit address rolls from 3ffh to 000h with no gap.
            if (tx_take && state_reg == ST_READ) begin
                rd_addr_reg <= rd_addr_reg + 10'h001;
            end
            if (cs_rise) begin
                end_pend_reg <= 1'b1;
                end_aln_reg <= cs_aligned;
            end
        end
    end

    // Write-enable latch; a hardware set by 06h beats every clear.
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            wen_reg <= 1'b0;
        end else if (end_go && cmd_reg == OPC_WR_EN &&
                     end_aln_reg) begin
            wen_reg <= 1'b1;
        end else if (end_go && cmd_reg == OPC_WR_DIS && end_aln_reg) begin
            wen_reg <= 1'b0;
        end else if (end_go && cmd_reg == OPC_SEC_ERASE && !erase_ok) begin
            wen_reg <= 1'b0;
        end else if (end_go && cmd_reg == OPC_SEC_PROG && !prog_ok) begin
            wen_reg <= 1'b0;
        end else if (eng_done) begin
            wen_reg <= 1'b0;
        end
    end

    // Self-timed engine: a 256-cycle array sweep inside a longer busy time.
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            sweep_reg <= 1'b0;
            erase_mode_reg <= 1'b0;
            idx_reg <= 8'h00;
            page_reg <= 2'h0;
            tmr_reg <= '0;
        end else if (end_go && (erase_ok || prog_ok)) begin
            busy_reg <= 1'b1;
            sweep_reg <= 1'b1;
            erase_mode_reg <= erase_ok;
            idx_reg <= 8'h00;
            page_reg <= addr_reg[9:8];
            tmr_reg <= erase_ok ? TMR_W'(ERASE_CYC - 1) :
                                  TMR_W'(PROG_CYC - 1);
        end else if (busy_reg) begin
            if (sweep_reg) begin
                idx_reg <= idx_reg + 8'h01;
                if (idx_reg == 8'hff) begin
                    sweep_reg <= 1'b0;
                end
            end
            if (tmr_reg == '0) begin
                busy_reg <= 1'b0;
            end else begin
                tmr_reg <= tmr_reg - TMR_W'(1);
            end
        end
    end

    // Page array; programming only clears bits, as flash cells do.
    always_ff @(posedge i_mclk) begin
        if (sweep_reg) begin
            if (erase_mode_reg) begin
                mem[{page_reg, idx_reg}] <= ERASED_BYTE;
            end else if (mask_reg[idx_reg]) begin
                mem[{page_reg, idx_reg}] <=
                    mem[{page_reg, idx_reg}] & pbuf[idx_reg];
            end
        end
    end

    // Program buffer fill; the offset wraps inside the page.
    always_ff @(posedge i_mclk) begin
        if (pop && !end_go && state_reg == ST_DATA) begin
            pbuf[off_reg] <= rx;
        end
    end

    // Marks which buffer bytes this command wrote; stale bytes stay out.
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= '0;
        end else if (pop && !end_go && state_reg == ST_OPC &&
                     rx == OPC_SEC_PROG && !busy_reg) begin
            mask_reg <= '0;
        end else if (pop && !end_go && state_reg == ST_DATA) begin
            mask_reg[off_reg] <= 1'b1;
        end
    end

    // Protection bits; the pin only decides whether they may change.
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            prot_reg <= PROT_RST;
            refused_reg <= 1'b0;
        end else begin
            refused_reg <= 1'b0;
            if (i_prot_wr && !wp_n_s) begin
                refused_reg <= 1'b1;
            end else if (i_prot_wr) begin
                prot_reg <= i_prot_data;
            end
        end
    end

    // One-time lock bits: ones are OR-ed in and nothing clears them.
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg <= LOCK_RST;
        end else if (i_lock_wr) begin
            lock_reg <= lock_reg | i_lock_data;
        end
    end

    // Output driven only inside a frame that streams data.
    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= cs_n_s | ~tx_en_reg | end_pend_reg;
        end
    end

    assign o_so_oe_n = oe_n_reg;
    assign o_prot_bits = prot_reg;
    assign o_prot_refused = refused_reg;
    assign o_lock_bits = lock_reg;
    assign o_busy = busy_reg;
    assign o_wen = wen_reg;
endmodule : sps_top
`default_nettype wire

/* verif/sps_asserts.sv */
// Port checker for the security page command engine.
`default_nettype none
module sps_asserts (
    input wire logic i_mclk, i_rst_n, i_cs_n, i_wp_n, i_prot_wr,
    input wire logic o_so_oe_n, o_busy, o_wen, o_prot_refused,
    input wire logic [5:0] i_prot_data, o_prot_bits,
    input wire logic [2:0] o_lock_bits
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // The pin is judged two cycles back, as it crosses two flops.
    prot_set_a: assert property (
        i_prot_wr && $past(i_wp_n, 2)
        |=> o_prot_bits == $past(i_prot_data)) else $error("prot lost");
    prot_hold_a: assert property (
        i_prot_wr && !$past(i_wp_n, 2)
        |=> o_prot_refused && $stable(o_prot_bits)) else $error("prot moved");
    prot_cause_a: assert property (
        $changed(o_prot_bits) |-> $past(i_prot_wr)) else $error("prot drift");
    lock_keep_a: assert property (
        (o_lock_bits & $past(o_lock_bits)) == $past(o_lock_bits))
        else $error("lock cleared");
    busy_start_a: assert property (
        $rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2) ##1 o_busy [*8])
        else $error("busy early");
    busy_end_a: assert property (
        $fell(o_busy) |-> ##[0:2] !o_wen) else $error("latch kept");
    wen_set_a: assert property (
        $rose(o_wen) |-> i_cs_n) else $error("latch mid frame");
    so_float_a: assert property (
        i_cs_n [*6] |-> o_so_oe_n) else $error("output driven");
    cover property ($fell(o_busy));
    cover property (o_prot_refused);
    cover property ($fell(o_so_oe_n));
endmodule : sps_asserts
bind sps_top sps_asserts i_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_cs_n(i_cs_n), .i_wp_n(i_wp_n), .i_prot_wr(i_prot_wr),
    .o_so_oe_n(o_so_oe_n), .o_busy(o_busy), .o_wen(o_wen),
    .o_prot_refused(o_prot_refused), .i_prot_data(i_prot_data),
    .o_prot_bits(o_prot_bits), .o_lock_bits(o_lock_bits));
`default_nettype wire

/* verif/sps_host.sv */
// Host controller model that clocks command frames in mode 0.
`default_nettype none
module sps_host (
    input wire logic i_clk, i_so,
    output logic o_cs_n = 1'b1, o_sclk = 1'b0, o_si = 1'b0, o_vld = 1'b0,
    output logic [7:0] o_byte = 8'h00
);
    timeunit 1ns;
    timeprecision 1ns;
    // Slow enough for the pin synchronisers.
    localparam int HALF = 20;
    // Sends nb bits MSB first; whole bytes after skip bytes are reported.
    task automatic frame(input logic [7:0] tx[$], input int nb, skip);
        logic [7:0] sh;
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            @(posedge i_clk);
            o_si <= tx[i / 8][7 - i % 8];
            repeat (HALF) @(posedge i_clk);
            o_sclk <= 1'b1;
            sh = {sh[6:0], i_so};
            o_byte <= sh;
            o_vld <= i % 8 == 7 && i >= skip * 8;
            @(posedge i_clk);
            o_vld <= 1'b0;
            repeat (HALF) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        // A released line must not keep its last value.
        @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_si <= ~o_si;
        repeat (HALF) @(posedge i_clk);
    endtask : frame
endmodule : sps_host
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the security page command engine.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sps_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wp_n = 1'b1, prot_wr = 1'b0;
    logic lock_wr = 1'b0, cs_n, sclk, si, so, oe_n, refd, busy, wen, vld;
    logic [5:0] prot_d = 6'h00, prot;
    logic [2:0] lock_d = 3'h0, lock;
    logic [7:0] rx, d[3], exp_q[$];
    int fails = 0, n_compared = 0;
    // Free-running 25 MHz clock.
    always #20 clk = ~clk;
    sps_top #(.ERASE_CYC(300), .PROG_CYC(300)) i_dut (.i_mclk(clk),
        .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si), .o_so(so),
        .o_so_oe_n(oe_n), .i_wp_n(wp_n), .i_prot_wr(prot_wr),
        .i_prot_data(prot_d), .o_prot_bits(prot), .o_prot_refused(refd),
        .i_lock_wr(lock_wr), .i_lock_data(lock_d), .o_lock_bits(lock),
        .o_busy(busy), .o_wen(wen));
    sps_host i_host (.i_clk(clk), .i_so(so), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_si(si), .o_vld(vld), .o_byte(rx));
    task automatic chk(input logic [7:0] e, a);
        n_compared++;
        if (a !== e) begin
            fails++;
            $display("[FAIL] %0t exp %h got %h", $time, e, a);
        end
    endtask : chk
    // Status byte: lock bits, latch, busy flag.
    task automatic st(input logic [7:0] e);
        chk(e, {3'h0, lock, wen, busy});
    endtask : st
    // Optional write enable, then a page erase with a random low byte.
    task automatic er(input logic [7:0] p, input int nb, input bit w);
        if (w) i_host.frame('{OPC_WR_EN}, 8, 9);
        i_host.frame('{OPC_SEC_ERASE, 8'h00, p, 8'($urandom), 8'h00}, nb, 9);
    endtask : er
    task automatic give_verdict();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // Read bytes are matched against the oldest expectation.
    always @(posedge clk) if (vld) begin
        chk(exp_q.pop_front(), rx);
        chk(8'h00, {7'h0, oe_n});
    end
    // Hang guard, about three and a half times the expected run.
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        give_verdict();
    end
    initial begin
        void'($urandom(59));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        er(8'h01, 32, 0);
        st(8'h00);
        i_host.frame('{OPC_WR_EN}, 8, 9);
        st(8'h02);
        er(8'h02, 33, 0);
        st(8'h00);
        er(8'h02, 32, 1);
        st(8'h03);
        repeat (400) if (busy) @(posedge clk);
        st(8'h00);
        foreach (d[i]) d[i] = 8'($urandom);
        i_host.frame('{OPC_WR_EN}, 8, 9);
        i_host.frame('{OPC_SEC_PROG, 8'h00, 8'h02, 8'hfd, d[0], d[1], d[2]},
            56, 9);
        st(8'h03);
        repeat (400) if (busy) @(posedge clk);
        exp_q = '{d[0], d[1], d[2]};
        i_host.frame('{OPC_SEC_READ, 8'h00, 8'h02, 8'hfd, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h00}, 68, 5);
        chk(8'h00, 8'(exp_q.size()));
        @(posedge clk);
        lock_wr <= 1'b1;
        lock_d <= 3'h2;
        @(posedge clk);
        lock_wr <= 1'b0;
        er(8'h02, 32, 1);
        st(8'h08);
        exp_q = '{d[2]};
        i_host.frame('{OPC_SEC_READ, 8'h00, 8'h02, 8'hff, 8'h00, 8'h00},
            48, 5);
        chk(8'h00, 8'(exp_q.size()));
        er(8'h01, 32, 1);
        st(8'h0b);
        // Protection write with the pin high, then one refused with it low.
        prot_wr <= 1'b1;
        prot_d <= 6'($urandom);
        @(posedge clk);
        prot_wr <= 1'b0;
        wp_n <= 1'b0;
        repeat (4) @(posedge clk);
        prot_wr <= 1'b1;
        prot_d <= ~prot_d;
        @(posedge clk);
        prot_wr <= 1'b0;
        @(negedge clk);
        chk(8'h01, {7'h0, refd});
        chk({2'h0, ~prot_d}, {2'h0, prot});
        give_verdict();
    end
endmodule : tb
`default_nettype wire
